// file: rtl/ibc_pkg.sv
// Constants, register map and types of the bus line control block.
package ibc_pkg;

   localparam logic [7:0] IBC_CTRL1_OFS = 8'h00;
   localparam logic [7:0] IBC_MODE2_OFS = 8'h04;
   localparam logic [7:0] IBC_MODE3_OFS = 8'h08;
   localparam logic [7:0] IBC_STAT_OFS  = 8'h0c;
   localparam logic [7:0] IBC_CLR_OFS   = 8'h10;
   localparam logic [7:0] IBC_IEN_OFS   = 8'h14;
   localparam logic [7:0] IBC_RXD_OFS   = 8'h18;

   localparam int IBC_SDA_MON_BIT  = 0;
   localparam int IBC_SCL_MON_BIT  = 1;
   localparam int IBC_SDA_OUT_BIT  = 2;
   localparam int IBC_SCL_OUT_BIT  = 3;
   localparam int IBC_IRST_BIT     = 4;
   localparam int IBC_ICE_BIT      = 7;
   localparam int IBC_HIGH_TIMEOUT_COUNT_ENABLE_BIT     = 1;
   localparam int IBC_LOW_TIMEOUT_COUNT_ENABLE_BIT     = 2;
   localparam int IBC_ACKNOWLEDGE_TRANSMIT_BIT_BIT    = 3;
   localparam int IBC_RECEIVE_FLAG_TIMING_SELECT_BIT    = 5;
   localparam int IBC_STS_RECEIVE_DATA_FULL_FLAG_BIT = 0;
   localparam int IBC_STS_TMO_BIT  = 1;

   localparam logic [3:0]  IBC_BITS_DATA = 4'h8;
   localparam logic [3:0]  IBC_BITS_ACK  = 4'h9;
   localparam logic [15:0] IBC_TMO_TERM  = 16'h03ff;
   localparam logic [1:0]  IBC_LINE_IDLE = 2'h3;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0001,
      BUS_WR   = 4'b0010,
      BUS_RDW  = 4'b0100,
      BUS_RDD  = 4'b1000
   } ibc_bus_e;

endpackage : ibc_pkg

// file: rtl/ibc_line_sync.sv
// Two-flop synchronisers and edge finders for the SDA and SCL lines.
`timescale 1ns/1ps
module ibc_line_sync
   import ibc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [1:0] line_in,
   output logic      [1:0] level,
   output logic      [1:0] rise,
   output logic      [1:0] fall
);

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } ibc_sync_s;

   ibc_sync_s st_r;
   ibc_sync_s st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = line_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   // Lines idle high, so reset to high to avoid a false edge at start.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '{s1: IBC_LINE_IDLE, s2: IBC_LINE_IDLE, s3: IBC_LINE_IDLE};
      end else begin
         st_r <= st_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_edge
         assign level[g] = st_r.s2[g];
         assign rise[g]  = st_r.s2[g] & ~st_r.s3[g];
         assign fall[g]  = ~st_r.s2[g] & st_r.s3[g];
      end
   endgenerate

endmodule : ibc_line_sync

// file: rtl/ibc_line_ctrl.sv
// AHB-Lite line control and receive timing block for an I2C interface.
// Function
// - SDA monitor bit reads line level.
// - SCL monitor bit reads line level.
// - SDA output bit drives low or releases.
// - SCL output bit drives low or releases.
// - Reset bit clears counter, releases output latches.
// - Enable bit zero keeps both pins inactive.
// - Enable and reset bits choose reset kind.
// - Low timeout enable counts while SCL low.
// - High timeout enable counts while SCL high.
// - Select zero: flag at ninth rise, no hold.
// - Select one: flag at eighth rise, hold.
// - Acknowledge bit write releases SCL hold.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module ibc_line_ctrl
   import ibc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   output logic             irq
);

   typedef struct packed {
      ibc_bus_e    bus;
      logic [7:0]  addr;
      logic [31:0] rdata;
      logic        interface_enable_bit;
      logic        irst;
      logic        data_output_control;
      logic        clock_output_control;
      logic        low_timeout_count_enable;
      logic        high_timeout_count_enable;
      logic        receive_flag_timing_select;
      logic        acknowledge_transmit_bit;
      logic        hold;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  rxdata;
      logic [1:0]  sts;
      logic [1:0]  ien;
      logic [15:0] tmo_cnt;
      logic        sda_oe;
      logic        scl_oe;
      logic        irq;
   } ibc_state_s;

   localparam ibc_state_s ST_RESET = '{
      bus: BUS_IDLE, data_output_control: 1'b1, clock_output_control: 1'b1, default: '0};

   ibc_state_s st_r;
   ibc_state_s st_nxt;

   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;

   // Bit 0 is SDA, bit 1 is SCL.
   ibc_line_sync u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .line_in ({scl_i, sda_i}),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   logic        sda_lvl;
   logic        scl_lvl;
   logic        scl_edge;
   logic        active;
   logic [31:0] rd;
   logic [1:0]  sts_set;
   logic [1:0]  sts_clr;
   logic [7:0]  shift;

   assign sda_lvl  = lvl[0];
   assign scl_lvl  = lvl[1];
   assign scl_edge = rise[1] | fall[1];

   always_comb begin
      st_nxt  = st_r;
      rd      = '0;
      sts_set = '0;
      sts_clr = '0;
      shift   = {st_r.shreg[6:0], sda_lvl};
      active  = st_r.interface_enable_bit & ~st_r.irst;

      if (st_r.addr == IBC_CTRL1_OFS) begin
         rd[IBC_SDA_MON_BIT] = sda_lvl;
         rd[IBC_SCL_MON_BIT] = scl_lvl;
         rd[IBC_SDA_OUT_BIT] = st_r.data_output_control;
         rd[IBC_SCL_OUT_BIT] = st_r.clock_output_control & ~st_r.hold;
         rd[IBC_IRST_BIT]    = st_r.irst;
         rd[IBC_ICE_BIT]     = st_r.interface_enable_bit;
      end else if (st_r.addr == IBC_MODE2_OFS) begin
         rd[IBC_HIGH_TIMEOUT_COUNT_ENABLE_BIT] = st_r.high_timeout_count_enable;
         rd[IBC_LOW_TIMEOUT_COUNT_ENABLE_BIT] = st_r.low_timeout_count_enable;
      end else if (st_r.addr == IBC_MODE3_OFS) begin
         rd[IBC_ACKNOWLEDGE_TRANSMIT_BIT_BIT] = st_r.acknowledge_transmit_bit;
         rd[IBC_RECEIVE_FLAG_TIMING_SELECT_BIT] = st_r.receive_flag_timing_select;
      end else if (st_r.addr == IBC_STAT_OFS) begin
         rd[1:0] = st_r.sts;
      end else if (st_r.addr == IBC_IEN_OFS) begin
         rd[1:0] = st_r.ien;
      end else if (st_r.addr == IBC_RXD_OFS) begin
         rd[7:0] = st_r.rxdata;
      end

      // Receive path runs only while enabled and out of reset.
      if (active) begin
         if (fall[0] && scl_lvl) begin
            st_nxt.bitcnt = '0;
         end else if (rise[0] && scl_lvl) begin
            st_nxt.bitcnt = '0;
            st_nxt.hold   = 1'b0;
         end else if (rise[1]) begin
            st_nxt.shreg  = shift;
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
            if (st_r.bitcnt == IBC_BITS_DATA - 4'h1) begin
               st_nxt.rxdata = shift;
               if (st_r.receive_flag_timing_select) begin
                  sts_set[IBC_STS_RECEIVE_DATA_FULL_FLAG_BIT] = 1'b1;
               end
            end else if (st_r.bitcnt == IBC_BITS_ACK - 4'h1) begin
               st_nxt.bitcnt = '0;
               if (!st_r.receive_flag_timing_select) begin
                  sts_set[IBC_STS_RECEIVE_DATA_FULL_FLAG_BIT] = 1'b1;
               end
            end
         end else if (fall[1] && st_r.bitcnt == IBC_BITS_DATA) begin
            st_nxt.hold = st_r.receive_flag_timing_select;
         end

         // Any SCL edge reloads the timeout count.
         if (scl_edge) begin
            st_nxt.tmo_cnt = '0;
         end else if ((!scl_lvl && st_r.low_timeout_count_enable) ||
                      (scl_lvl && st_r.high_timeout_count_enable)) begin
            if (st_r.tmo_cnt == IBC_TMO_TERM) begin
               sts_set[IBC_STS_TMO_BIT] = 1'b1;
               st_nxt.tmo_cnt = '0;
            end else begin
               st_nxt.tmo_cnt = st_r.tmo_cnt + 16'h0001;
            end
         end
      end

      case (st_r.bus)
         BUS_WR: begin
            if (st_r.addr == IBC_CTRL1_OFS) begin
               st_nxt.data_output_control = hwdata[IBC_SDA_OUT_BIT];
               st_nxt.clock_output_control = hwdata[IBC_SCL_OUT_BIT];
               st_nxt.irst = hwdata[IBC_IRST_BIT];
               st_nxt.interface_enable_bit  = hwdata[IBC_ICE_BIT];
            end else if (st_r.addr == IBC_MODE2_OFS) begin
               st_nxt.high_timeout_count_enable = hwdata[IBC_HIGH_TIMEOUT_COUNT_ENABLE_BIT];
               st_nxt.low_timeout_count_enable = hwdata[IBC_LOW_TIMEOUT_COUNT_ENABLE_BIT];
            end else if (st_r.addr == IBC_MODE3_OFS) begin
               st_nxt.acknowledge_transmit_bit = hwdata[IBC_ACKNOWLEDGE_TRANSMIT_BIT_BIT];
               st_nxt.receive_flag_timing_select = hwdata[IBC_RECEIVE_FLAG_TIMING_SELECT_BIT];
               st_nxt.hold  = 1'b0;
            end else if (st_r.addr == IBC_CLR_OFS) begin
               sts_clr = hwdata[1:0];
            end else if (st_r.addr == IBC_IEN_OFS) begin
               st_nxt.ien = hwdata[1:0];
            end
         end
         BUS_RDW: begin
            st_nxt.rdata = rd;
         end
         default: begin
         end
      endcase

      // A flag raised in the cycle of its clear stays raised.
      st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;

      // Reset bit held: internal reset when enabled, full reset otherwise.
      if (st_r.irst) begin
         st_nxt.bitcnt = '0;
         st_nxt.data_output_control   = 1'b1;
         st_nxt.clock_output_control   = 1'b1;
         st_nxt.hold   = 1'b0;
         if (!st_r.interface_enable_bit) begin
            st_nxt.sts     = '0;
            st_nxt.shreg   = '0;
            st_nxt.rxdata  = '0;
            st_nxt.tmo_cnt = '0;
         end
      end

      if (hsel && htrans[1] && hready) begin
         st_nxt.bus  = hwrite ? BUS_WR : BUS_RDW;
         st_nxt.addr = haddr[7:0];
      end else if (st_r.bus == BUS_RDW) begin
         st_nxt.bus = BUS_RDD;
      end else begin
         st_nxt.bus = BUS_IDLE;
      end

      st_nxt.sda_oe = st_nxt.interface_enable_bit & ~st_nxt.data_output_control;
      st_nxt.scl_oe = st_nxt.interface_enable_bit & (~st_nxt.clock_output_control | st_nxt.hold);
      st_nxt.irq    = |(st_nxt.sts & st_nxt.ien);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Reads take one wait state so the data word comes from a register.
   assign hreadyout = (st_r.bus != BUS_RDW);
   assign hrdata    = st_r.rdata;
   assign hresp     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_o     = 1'b0;
   assign sda_oe    = st_r.sda_oe;
   assign scl_oe    = st_r.scl_oe;
   assign irq       = st_r.irq;

   AST_SDA_MON: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.bus == BUS_RDD && st_r.addr == IBC_CTRL1_OFS)
      |-> hrdata[IBC_SDA_MON_BIT] == $past(sda_lvl))
      else $error("SDA monitor bit differs from line");

   AST_SCL_MON: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.bus == BUS_RDD && st_r.addr == IBC_CTRL1_OFS)
      |-> hrdata[IBC_SCL_MON_BIT] == $past(scl_lvl))
      else $error("SCL monitor bit differs from line");

   AST_SDA_DRIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.bus == BUS_WR && st_r.addr == IBC_CTRL1_OFS &&
       hwdata[IBC_ICE_BIT] && !hwdata[IBC_IRST_BIT] && !st_r.irst)
      |=> sda_oe == !$past(hwdata[IBC_SDA_OUT_BIT]))
      else $error("SDA drive does not follow written bit");

   AST_SCL_DRIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.bus == BUS_WR && st_r.addr == IBC_CTRL1_OFS &&
       hwdata[IBC_ICE_BIT] && !hwdata[IBC_SCL_OUT_BIT] && !st_r.irst)
      |=> scl_oe)
      else $error("SCL not driven low after write");

   AST_IRST: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.irst |=> (st_r.bitcnt == 4'h0 && !sda_oe && !st_r.hold))
      else $error("Reset bit did not clear counter or release");

   AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!nrst)
      !st_r.interface_enable_bit |-> !sda_oe && !scl_oe)
      else $error("Pin driven while interface disabled");

   AST_FULL_RST: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.irst && !st_r.interface_enable_bit) [*2] |-> st_r.sts == 2'h0)
      else $error("Full reset left status set");

   AST_TMO_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.interface_enable_bit && !st_r.irst && st_r.low_timeout_count_enable && !scl_lvl && !scl_edge &&
       st_r.tmo_cnt != IBC_TMO_TERM)
      |=> st_r.tmo_cnt == $past(st_r.tmo_cnt) + 16'h0001)
      else $error("Timeout count stalled while SCL low");

   AST_TMO_HIGH: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.interface_enable_bit && !st_r.irst && !st_r.high_timeout_count_enable && scl_lvl && !scl_edge)
      |=> $stable(st_r.tmo_cnt))
      else $error("Timeout counted while high count disabled");

   AST_RECEIVE_DATA_FULL_FLAG_NINTH: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.interface_enable_bit && !st_r.irst && !st_r.receive_flag_timing_select && rise[1] && !rise[0] &&
       !fall[0] && st_r.bitcnt == IBC_BITS_DATA)
      |=> st_r.sts[IBC_STS_RECEIVE_DATA_FULL_FLAG_BIT] && st_r.bitcnt == 4'h0)
      else $error("Receive flag missing at ninth rise");

   AST_HOLD_EIGHTH: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.interface_enable_bit && !st_r.irst && st_r.receive_flag_timing_select && fall[1] &&
       st_r.bitcnt == IBC_BITS_DATA && st_r.bus != BUS_WR)
      |=> st_r.hold ##1 scl_oe)
      else $error("SCL not held after eighth clock");

   AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.hold && st_r.bus == BUS_WR && st_r.addr == IBC_MODE3_OFS)
      |=> !st_r.hold)
      else $error("Hold not released by acknowledge write");

   AST_TMO_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.interface_enable_bit && !st_r.irst && st_r.tmo_cnt == IBC_TMO_TERM &&
       !scl_edge && (scl_lvl ? st_r.high_timeout_count_enable : st_r.low_timeout_count_enable))
      |=> st_r.sts[IBC_STS_TMO_BIT] && st_r.tmo_cnt == 16'h0000)
      else $error("Timeout flag not set at terminal count");

endmodule : ibc_line_ctrl

// file: verif/ibc_i2c_peer.sv
// Behavioural bus master that drives the link lines of the block.
`timescale 1ns/1ps
module ibc_i2c_peer (
   input  wire logic scl_w,
   output logic      scl_d,
   output logic      sda_d
);
   initial begin
      scl_d = 1'b1;
      sda_d = 1'b1;
   end
   // Edges are offset from the block's clock edge, except the SCL fall after a stretched low phase, which lands on one.
   task automatic start;
      #13;
      sda_d = 1'b0;
      #160;
      scl_d = 1'b0;
   endtask : start
   task automatic bit_out(input logic b);
      #13;
      sda_d = b;
      #147;
      scl_d = 1'b1;
      // The block may stretch the low phase, so wait on the wire itself.
      wait (scl_w === 1'b1);
      #160;
      scl_d = 1'b0;
   endtask : bit_out
   task automatic stop;
      #13;
      sda_d = 1'b0;
      #147;
      scl_d = 1'b1;
      #160;
      sda_d = 1'b1;
   endtask : stop
   task automatic set_scl(input logic v);
      scl_d = v;
   endtask : set_scl
endmodule : ibc_i2c_peer

// file: verif/ibc_line_ctrl_bench.sv
// Self-checking bench for the bus line control block.
`timescale 1ns/1ps
module ibc_line_ctrl_bench
   import ibc_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic        hreadyout, hresp, sda_o, sda_oe, scl_o, scl_oe, irq;
   logic [31:0] hrdata, rd, lfsr_r;
   logic        p_scl, p_sda, scl_w, sda_w;
   logic [7:0]  dat;
   // Reference model: bytes sent by the peer wait here until read back.
   logic [7:0]  exp_q [$];
   logic [31:0] tm [4] = '{32'h4, 32'h2, 32'h4, 32'h2};
   logic [1:0]  lv [4] = '{2'h1, 2'h0, 2'h0, 2'h1};
   logic [1:0]  ex [4] = '{2'h0, 2'h0, 2'h1, 2'h1};
   logic [7:0]  ofs [6] = '{IBC_MODE2_OFS, IBC_MODE3_OFS, IBC_STAT_OFS,
                           IBC_IEN_OFS, IBC_RXD_OFS, 8'h1c};
   int          bad_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   // Both lines have pull-ups; any party that pulls low wins.
   assign scl_w = (scl_oe ? scl_o : 1'b1) & p_scl;
   assign sda_w = (sda_oe ? sda_o : 1'b1) & p_sda;
   always #20 sys_clk = ~sys_clk;
   ibc_line_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .irq(irq));
   ibc_i2c_peer p (.scl_w(scl_w), .scl_d(p_scl), .sda_d(p_sda));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic chk_reg(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_pin(input string n, input logic e, g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask : chk_pin
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(negedge sys_clk);
      while (hreadyout !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(negedge sys_clk);
      while (hreadyout !== 1'b1) @(negedge sys_clk);
      rd = hrdata;
      chk_pin("hresp", 1'b0, hresp);
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk_reg("register", e, rd);
   endtask : rdc
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   // The longest path is the four timeout cases, well under this ceiling.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      lfsr_r = 32'h95c23993;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rdc(IBC_CTRL1_OFS, 32'h0f);
      foreach (ofs[i]) rdc(ofs[i], 32'h0);
      $display("test reset values done");
      wr(IBC_CTRL1_OFS, 32'h00);
      idle(3);
      chk_pin("sda_oe", 1'b0, sda_oe);
      chk_pin("scl_oe", 1'b0, scl_oe);
      foreach (tm[i]) begin
         dat = 8'h80 | (i[1:0] << 2);
         wr(IBC_CTRL1_OFS, {24'h0, dat});
         idle(4);
         chk_pin("sda_oe", ~dat[2], sda_oe);
         chk_pin("scl_oe", ~dat[3], scl_oe);
         rdc(IBC_CTRL1_OFS, {24'h0, dat[7:2], dat[3], dat[2]});
      end
      wr(IBC_CTRL1_OFS, 32'h90);
      idle(3);
      chk_pin("sda_oe", 1'b0, sda_oe);
      chk_pin("scl_oe", 1'b0, scl_oe);
      rdc(IBC_CTRL1_OFS, 32'h9f);
      wr(IBC_CTRL1_OFS, 32'h8c);
      $display("test line control done");
      for (int s = 0; s < 2; s++) begin
         lfsr_r = lfsr(lfsr_r);
         dat = lfsr_r[7:0];
         wr(IBC_MODE3_OFS, 32'(s) << 5);
         wr(IBC_CLR_OFS, 32'h3);
         p.start();
         for (int i = 7; i >= 0; i--) p.bit_out(dat[i]);
         exp_q.push_back(dat);
         idle(8);
         rdc(IBC_RXD_OFS, {24'h0, exp_q.pop_front()});
         rdc(IBC_STAT_OFS, 32'(s));
         chk_pin("scl_oe", s[0], scl_oe);
         if (s == 1) rdc(IBC_CTRL1_OFS, 32'h84 | dat[0]);
         fork
            p.bit_out(1'b1);
            begin
               idle(8);
               wr(IBC_MODE3_OFS, (32'(s) << 5) | 32'h8);
            end
         join
         idle(4);
         chk_pin("scl_oe", 1'b0, scl_oe);
         rdc(IBC_STAT_OFS, 32'h1);
         p.stop();
      end
      wr(IBC_CTRL1_OFS, 32'h9c);
      rdc(IBC_STAT_OFS, 32'h1);
      wr(IBC_CTRL1_OFS, 32'h8c);
      $display("test receive done");
      wr(IBC_IEN_OFS, 32'h1);
      idle(2);
      chk_pin("irq", 1'b1, irq);
      wr(IBC_IEN_OFS, 32'h0);
      idle(2);
      chk_pin("irq", 1'b0, irq);
      wr(IBC_IEN_OFS, 32'h1);
      wr(IBC_CLR_OFS, 32'h1);
      idle(2);
      chk_pin("irq", 1'b0, irq);
      $display("test interrupt done");
      foreach (tm[k]) begin
         wr(IBC_MODE2_OFS, tm[k]);
         p.set_scl(~lv[k][0]);
         idle(4);
         p.set_scl(lv[k][0]);
         idle(4);
         wr(IBC_CLR_OFS, 32'h2);
         idle(1100);
         rdc(IBC_STAT_OFS, {30'h0, ex[k][0], 1'b0});
      end
      wr(IBC_CTRL1_OFS, 32'h1c);
      wr(IBC_CTRL1_OFS, 32'h8c);
      rdc(IBC_STAT_OFS, 32'h0);
      rdc(IBC_RXD_OFS, 32'h0);
      $display("test timeout done");
      complete_run();
   end
endmodule : ibc_line_ctrl_bench
